/* src/kpl_panel.sv */
// Keypad entry, parameter store, mode, range and limit alarm logic.
// Assumes keys arrive as one-cycle pulses and levels are pre-digitised.
//
// Overview of operation
// - Parameters survive power cycling unchanged
// - Parameters stored and applied per channel
// - Function keys recall last entered value
// - Numeric key suspends measurement, starts entry
// - Digits shift in right, four maximum
// - Point goes after rightmost digit
// - Sign key toggles entry sign
// - Erase key discards partial entry
// - Function key commits entry, resumes measuring
// - Four display modes: mV, three dB
// - Nonzero reference lights lamp in dBm mode outside difference, offsets dBm
// - dB values in hundredths of dB
// - Auto range steps to best range
// - Range hold freezes present range
// - Per-channel limits drive lamp and output
// - Linear mode compares using last dB mode
// - Difference mode checks both channels
// - Limits accepted within plus/minus 99.99
// - Error codes one small, two large
// - Impedance accepted from 50 to 600
// - Difference shows channel 1 minus 2
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module kpl_panel
    import kpl_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire kpl_key_type key_i,
    input wire logic [15:0] level_mv_ch1_i,
    input wire logic [15:0] level_mv_ch2_i,
    input wire logic signed [15:0] level_dbmv_ch1_i,
    input wire logic signed [15:0] level_dbmv_ch2_i,
    input wire logic signed [15:0] level_dbm_ch1_i,
    input wire logic signed [15:0] level_dbm_ch2_i,
    input wire logic range_up_i,
    input wire logic range_down_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    output kpl_view_type view_o,
    output logic [15:0] entry_digits_o,
    output logic [2:0] entry_frac_o,
    output logic entry_point_o,
    output logic entry_neg_o,
    output logic [1:0] channel_o,
    output logic [21:0] impedance_o,
    output logic [1:0] range_o,
    output logic threshold_alarm_lamp_o,
    output logic alarm_output_connector_o,
    output logic relative_level_lamp_o
);
    // ------------------------------------------------------------------
    // Non-volatile parameter store
    // ------------------------------------------------------------------
    // Never touched by reset: models retained memory contents.
    logic signed [21:0] lo_lim [2] = '{-22'sd9999, -22'sd9999};
    logic signed [21:0] hi_lim [2] = '{22'sd9999, 22'sd9999};
    logic signed [21:0] ref_lvl [2] = '{22'sd0, 22'sd0};
    logic signed [21:0] zo_val [2] = '{22'sd5000, 22'sd5000};
    logic [1:0] mode [2] = '{MODE_DBM, MODE_DBM};
    logic [1:0] last_db [2] = '{MODE_DBM, MODE_DBM};
    logic [1:0] chan = 2'h1;
    logic hold = 1'b0;

    kpl_state_type state;
    logic [15:0] digits;
    logic [2:0] cnt;
    logic [2:0] frac;
    logic point;
    logic neg;
    logic [2:0] err_code;
    logic [4:0] recall_key;
    logic [31:0] ctrl;

    // ------------------------------------------------------------------
    // Key decode and entry value
    // ------------------------------------------------------------------
    wire is_digit = key_i.valid && key_i.code <= KEY_DIGIT_MAX;
    wire is_point = key_i.valid && key_i.code == KEY_POINT;
    wire is_sign = key_i.valid && key_i.code == KEY_SIGN_TOGGLE;
    wire is_erase = key_i.valid && key_i.code == KEY_ERASE_ENTRY;
    wire is_func = key_i.valid && key_i.code >= KEY_LOW_THRESHOLD
        && key_i.code <= KEY_REFERENCE_OFFSET;
    wire is_mode = key_i.valid && key_i.code >= KEY_LINEAR_VOLTS
        && key_i.code <= KEY_LOG_POWER;
    wire in_entry = state == ST_ENTRY;
    wire [1:0] key_mode = 2'(key_i.code - KEY_LINEAR_VOLTS);
    wire idx = chan == 2'h2;
    wire [13:0] ent_int = {10'h000, digits[15:12]} * 14'd1000
        + {10'h000, digits[11:8]} * 14'd100
        + {10'h000, digits[7:4]} * 14'd10 + {10'h000, digits[3:0]};
    wire [23:0] ent_ext = {10'h000, ent_int};
    logic [23:0] ent_mag;
    always_comb begin
        case (point ? frac : 3'h0)
            3'h0: ent_mag = ent_ext * 24'd100;
            3'h1: ent_mag = ent_ext * 24'd10;
            3'h2: ent_mag = ent_ext;
            3'h3: ent_mag = ent_ext / 24'd10;
            default: ent_mag = ent_ext / 24'd100;
        endcase
    end
    wire signed [21:0] ent_val = neg ? -$signed(ent_mag[21:0])
        : $signed(ent_mag[21:0]);

    // ------------------------------------------------------------------
    // Commit range check
    // ------------------------------------------------------------------
    wire code_zo = key_i.code == KEY_IMPEDANCE_CHOICE;
    wire code_ch = key_i.code == KEY_CHANNEL_CHOICE;
    wire signed [21:0] lo_bound = code_zo ? ZO_MIN
        : code_ch ? CH_ONE : LIMIT_MIN;
    wire signed [21:0] hi_bound = code_zo ? ZO_MAX
        : code_ch ? CH_DIFF : LIMIT_MAX;
    wire ch_bad = code_ch && ent_val != CH_ONE && ent_val != CH_TWO
        && ent_val != CH_DIFF;
    wire too_small = ent_val < lo_bound || (ch_bad && ent_val < CH_TWO);
    wire too_large = !too_small && (ent_val > hi_bound || ch_bad);
    wire commit = in_entry && is_func;
    wire commit_ok = commit && !too_small && !too_large;

    // ------------------------------------------------------------------
    // Entry register
    // ------------------------------------------------------------------
    wire start = !in_entry && (is_digit || is_point || is_sign || is_erase);
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || is_erase) begin
            digits <= 16'h0000;
            cnt <= 3'h0;
            frac <= 3'h0;
            point <= 1'b0;
            neg <= 1'b0;
        end else if (start) begin
            digits <= is_digit ? {12'h000, key_i.code[3:0]} : 16'h0000;
            cnt <= is_digit ? 3'h1 : 3'h0;
            frac <= 3'h0;
            point <= is_point;
            neg <= is_sign;
        end else if (in_entry && is_digit && cnt < MAX_DIGITS) begin
            digits <= {digits[11:0], key_i.code[3:0]};
            cnt <= cnt + 3'h1;
            frac <= point ? frac + 3'h1 : frac;
        end else if (in_entry && is_point && !point) begin
            point <= 1'b1;
        end else if (in_entry && is_sign) begin
            neg <= !neg;
        end
    end

    // ------------------------------------------------------------------
    // Entry state machine
    // ------------------------------------------------------------------
    kpl_state_type next_state;
    always_comb begin
        next_state = state;
        case (state)
            ST_MEAS:
                if (start) next_state = ST_ENTRY;
                else if (is_func) next_state = ST_RECALL;
            ST_ENTRY:
                if (commit_ok) next_state = ST_MEAS;
                else if (commit) next_state = ST_ERROR;
            ST_RECALL:
                if (start) next_state = ST_ENTRY;
                else if (key_i.valid && !is_func) next_state = ST_MEAS;
            ST_ERROR:
                if (key_i.valid) next_state = ST_MEAS;
            default: next_state = ST_MEAS;
        endcase
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state <= ST_MEAS;
            err_code <= 3'h0;
            recall_key <= KEY_LOW_THRESHOLD;
        end else begin
            state <= next_state;
            if (commit && !commit_ok) begin
                err_code <= too_small ? ERR_SMALL : ERR_LARGE;
            end
            if (is_func) begin
                recall_key <= key_i.code;
            end
        end
    end

    // ------------------------------------------------------------------
    // Parameter commit, mode and range keys
    // ------------------------------------------------------------------
    // Difference mode edits land on channel 1's set.
    always_ff @(posedge sys_clk_i) begin
        if (commit_ok) begin
            case (key_i.code)
                KEY_LOW_THRESHOLD: lo_lim[idx] <= ent_val;
                KEY_HIGH_THRESHOLD: hi_lim[idx] <= ent_val;
                KEY_IMPEDANCE_CHOICE: zo_val[idx] <= ent_val;
                KEY_REFERENCE_OFFSET: ref_lvl[idx] <= ent_val;
                default: chan <= 2'(ent_val / CH_ONE);
            endcase
        end
        if (is_mode && chan != 2'h3) begin
            mode[idx] <= key_mode;
            if (key_mode != LINEAR_VOLTS_MODE_KEY) begin
                last_db[idx] <= key_mode;
            end
        end
        if (key_i.valid && key_i.code == KEY_RANGE_AUTO) begin
            hold <= 1'b0;
        end else if (key_i.valid && key_i.code == KEY_RANGE_HOLD) begin
            hold <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            range_o <= 2'h0;
        end else if (!hold && range_up_i && range_o < RANGE_TOP) begin
            range_o <= range_o + 2'h1;
        end else if (!hold && range_down_i && range_o != 2'h0) begin
            range_o <= range_o - 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Displayed levels and limit compare
    // ------------------------------------------------------------------
    wire signed [21:0] dbmv [2] = '{22'(level_dbmv_ch1_i),
        22'(level_dbmv_ch2_i)};
    wire signed [21:0] dbm [2] = '{22'(level_dbm_ch1_i),
        22'(level_dbm_ch2_i)};
    logic signed [21:0] db_lvl [2];
    logic [1:0] over;
    for (genvar c = 0; c < 2; c++) begin : g_chan
        wire [1:0] eff = mode[c] == LINEAR_VOLTS_MODE_KEY ? last_db[c] : mode[c];
        always_comb begin
            case (eff)
                LOG_MILLIVOLT_MODE_KEY: db_lvl[c] = dbmv[c];
                LOG_VOLT_MODE_KEY: db_lvl[c] = dbmv[c] - DBV_SHIFT;
                default: db_lvl[c] = dbm[c] - ref_lvl[c];
            endcase
        end
        assign over[c] = db_lvl[c] > hi_lim[c]
            || db_lvl[c] < lo_lim[c];
    end
    wire signed [21:0] diff = db_lvl[0] - db_lvl[1];
    wire is_diff = chan == 2'h3;
    wire alarm_en = ctrl[0];
    wire next_alarm = alarm_en && (is_diff ? |over
        : over[idx]);
    wire next_lamp = !is_diff && mode[idx] == MODE_DBM
        && ref_lvl[idx] != 22'sd0;
    // Five recallable keys: a 2-bit index would fold reference onto low
    wire [2:0] rk = 3'(recall_key - KEY_LOW_THRESHOLD);
    wire signed [21:0] recall_val = rk == 3'h0 ? lo_lim[idx]
        : rk == 3'h1 ? hi_lim[idx] : rk == 3'h2 ? zo_val[idx]
        : recall_key == KEY_CHANNEL_CHOICE ? 22'(chan) * CH_ONE
        : ref_lvl[idx];
    wire [15:0] mv_sel = idx ? level_mv_ch2_i : level_mv_ch1_i;
    kpl_view_type next_view;
    always_comb begin
        next_view.kind = VIEW_DB;
        next_view.value = db_lvl[idx];
        case (state)
            ST_ENTRY: begin
                next_view.kind = VIEW_ENTRY;
                next_view.value = ent_val;
            end
            ST_RECALL: begin
                next_view.kind = VIEW_RECALL;
                next_view.value = recall_val;
            end
            ST_ERROR: begin
                next_view.kind = VIEW_ERROR;
                next_view.value = 22'(err_code);
            end
            default: begin
                if (is_diff) begin
                    next_view.kind = VIEW_DIFF;
                    next_view.value = diff;
                end else if (mode[idx] == LINEAR_VOLTS_MODE_KEY) begin
                    next_view.kind = VIEW_MV;
                    next_view.value = 22'({1'b0, mv_sel});
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    wire [31:0] status_word = {16'h0000, 1'b0, err_code, state,
        hold, range_o, chan, next_alarm, next_lamp, 1'b0};
    wire [31:0] rd_mux = reg_addr_i == OFS_STATUS ? status_word
        : reg_addr_i == OFS_CTRL ? ctrl
        : reg_addr_i == OFS_RANGE ? {30'h0, range_o} : 32'h0;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            ctrl <= CTRL_RESET;
            reg_rdata_o <= 32'h0;
        end else begin
            if (reg_write_i && reg_addr_i == OFS_CTRL) begin
                ctrl <= {31'h0, reg_wdata_i[0]};
            end
            reg_rdata_o <= reg_read_i ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            view_o <= '0;
            threshold_alarm_lamp_o <= 1'b0;
            alarm_output_connector_o <= 1'b0;
            relative_level_lamp_o <= 1'b0;
            channel_o <= 2'h1;
            impedance_o <= 22'h0;
            entry_digits_o <= 16'h0;
            entry_frac_o <= 3'h0;
            entry_point_o <= 1'b0;
            entry_neg_o <= 1'b0;
        end else begin
            view_o <= next_view;
            threshold_alarm_lamp_o <= next_alarm;
            alarm_output_connector_o <= next_alarm;
            relative_level_lamp_o <= next_lamp;
            channel_o <= chan;
            impedance_o <= zo_val[idx];
            entry_digits_o <= digits;
            entry_frac_o <= frac;
            entry_point_o <= point;
            entry_neg_o <= neg;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_digit_in_meas;
        state == ST_MEAS && is_digit;
    endsequence
    sequence s_entry_open;
        state == ST_ENTRY && cnt == 3'h1;
    endsequence
    a_entry_opens: assert property (s_digit_in_meas |=> s_entry_open)
        else $error("numeric key did not open entry");
    a_digit_cap: assert property (in_entry && cnt == MAX_DIGITS
        && is_digit && !is_erase |=> $stable(digits))
        else $error("fifth digit changed entry");
    a_point_frac: assert property (in_entry && point && is_digit
        && cnt < MAX_DIGITS |=> frac == $past(frac) + 3'h1)
        else $error("digit after point not counted");
    a_sign_flip: assert property (in_entry && is_sign
        |=> neg != $past(neg))
        else $error("sign key did not toggle");
    a_erase_all: assert property (is_erase |=> digits == 16'h0
        && cnt == 3'h0 && !neg && !point)
        else $error("erase left entry digits");
    sequence s_good_commit;
        commit_ok && key_i.code == KEY_LOW_THRESHOLD;
    endsequence
    a_commit_store: assert property (s_good_commit |=>
        state == ST_MEAS ##0 lo_lim[idx] == $past(ent_val))
        else $error("low threshold not stored");
    a_limit_bound: assert property (commit && key_i.code
        == KEY_HIGH_THRESHOLD && ent_val > LIMIT_MAX
        |=> state == ST_ERROR && err_code == ERR_LARGE)
        else $error("oversize limit accepted");
    a_small_code: assert property (commit && too_small
        |=> err_code == ERR_SMALL ##1 view_o.kind == VIEW_ERROR)
        else $error("small entry code wrong");
    a_zo_window: assert property (commit && code_zo && ent_val
        >= ZO_MIN && ent_val <= ZO_MAX |=> zo_val[idx] == $past(ent_val))
        else $error("valid impedance refused");
    a_hold_range: assert property (hold && !(key_i.valid
        && key_i.code == KEY_RANGE_AUTO) |=> $stable(range_o))
        else $error("range moved under hold");
    a_alarm_path: assert property (alarm_en && !is_diff
        && db_lvl[idx] == hi_lim[idx] && db_lvl[idx] >= lo_lim[idx]
        |=> !threshold_alarm_lamp_o && !alarm_output_connector_o)
        else $error("alarm on equality");
    a_diff_alarm: assert property (alarm_en && is_diff && over[1]
        |=> threshold_alarm_lamp_o)
        else $error("channel 2 limit ignored in difference");
    a_lamp_ref: assert property (state == ST_MEAS && !is_diff
        && mode[idx] == MODE_DBM && ref_lvl[idx] != 22'sd0
        |=> relative_level_lamp_o)
        else $error("reference lamp dark");
endmodule

/* src/kpl_pkg.sv */
// Constants and carrier types for the keypad parameter entry block.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package kpl_pkg;
    // ------------------------------------------------------------------
    // Widths and value limits (values in hundredths)
    // ------------------------------------------------------------------
    localparam int VAL_W = 22;
    localparam logic signed [21:0] LIMIT_MAX = 22'sd9999;
    localparam logic signed [21:0] LIMIT_MIN = -22'sd9999;
    localparam logic signed [21:0] ZO_MIN = 22'sd5000;
    localparam logic signed [21:0] ZO_MAX = 22'sd60000;
    localparam logic signed [21:0] CH_ONE = 22'sd100;
    localparam logic signed [21:0] CH_TWO = 22'sd200;
    localparam logic signed [21:0] CH_DIFF = 22'sd300;
    localparam logic signed [21:0] DBV_SHIFT = 22'sd6000;
    localparam logic [2:0] MAX_DIGITS = 3'h4;
    localparam logic [1:0] RANGE_TOP = 2'h3;

    // ------------------------------------------------------------------
    // Key codes
    // ------------------------------------------------------------------
    localparam logic [4:0] KEY_DIGIT_MAX = 5'h09;
    localparam logic [4:0] KEY_POINT = 5'h0a;
    localparam logic [4:0] KEY_SIGN_TOGGLE = 5'h0b;
    localparam logic [4:0] KEY_ERASE_ENTRY = 5'h0c;
    localparam logic [4:0] KEY_LOW_THRESHOLD = 5'h0d;
    localparam logic [4:0] KEY_HIGH_THRESHOLD = 5'h0e;
    localparam logic [4:0] KEY_IMPEDANCE_CHOICE = 5'h0f;
    localparam logic [4:0] KEY_CHANNEL_CHOICE = 5'h10;
    localparam logic [4:0] KEY_REFERENCE_OFFSET = 5'h11;
    localparam logic [4:0] KEY_LINEAR_VOLTS = 5'h12;
    localparam logic [4:0] KEY_LOG_MILLIVOLT = 5'h13;
    localparam logic [4:0] KEY_LOG_VOLT = 5'h14;
    localparam logic [4:0] KEY_LOG_POWER = 5'h15;
    localparam logic [4:0] KEY_RANGE_AUTO = 5'h16;
    localparam logic [4:0] KEY_RANGE_HOLD = 5'h17;

    // ------------------------------------------------------------------
    // Modes, display kinds, error codes
    // ------------------------------------------------------------------
    localparam logic [1:0] LINEAR_VOLTS_MODE_KEY = 2'h0;
    localparam logic [1:0] LOG_MILLIVOLT_MODE_KEY = 2'h1;
    localparam logic [1:0] LOG_VOLT_MODE_KEY = 2'h2;
    localparam logic [1:0] MODE_DBM = 2'h3;
    localparam logic [2:0] VIEW_MV = 3'h0;
    localparam logic [2:0] VIEW_DB = 3'h1;
    localparam logic [2:0] VIEW_ENTRY = 3'h2;
    localparam logic [2:0] VIEW_RECALL = 3'h3;
    localparam logic [2:0] VIEW_ERROR = 3'h4;
    localparam logic [2:0] VIEW_DIFF = 3'h5;
    localparam logic [2:0] ERR_SMALL = 3'h1;
    localparam logic [2:0] ERR_LARGE = 3'h2;

    // ------------------------------------------------------------------
    // Register port offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CTRL = 4'h4;
    localparam logic [3:0] OFS_RANGE = 4'h8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    typedef enum logic [3:0] {
        ST_MEAS = 4'b0001,
        ST_ENTRY = 4'b0010,
        ST_RECALL = 4'b0100,
        ST_ERROR = 4'b1000
    } kpl_state_type;

    typedef struct packed {
        logic valid;
        logic [4:0] code;
    } kpl_key_type;

    typedef struct packed {
        logic [2:0] kind;
        logic signed [21:0] value;
    } kpl_view_type;
endpackage

/* verif/kpl_keypad_model.sv */
// Keypad partner: each press is a one-cycle valid pulse on the key bus.
// Assumes the panel samples its key input on the rising clock edge.
`timescale 1ns/1ns
module kpl_keypad_model
    import kpl_pkg::*;
(
    input wire logic sys_clk_i,
    output kpl_key_type key_o
);
    initial key_o = '0;

    // The idle code is inverted so a stale code never repeats the key just pressed
    task automatic press(input logic [4:0] code, input int gap);
        @(posedge sys_clk_i);
        key_o <= '{valid: 1'b1, code: code};
        @(posedge sys_clk_i);
        key_o <= '{valid: 1'b0, code: ~code};
        repeat (gap) @(posedge sys_clk_i);
    endtask
endmodule

/* verif/kpl_panel_tb.sv */
// Self-checking bench for the keypad parameter entry block.
// Assumes a 100 MHz clock and the keypad model on the key port.
`timescale 1ns/1ns
`define CHK(a, e) \
    samples_checked++; \
    if ((a) !== (e)) begin \
        failures++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
    end
module kpl_panel_tb
    import kpl_pkg::*;
;
    // ----
    // Signals
    // ----
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    kpl_key_type key;
    logic [15:0] mv1 = '0;
    logic signed [15:0] dbmv1 = '0;
    logic signed [15:0] dbm1 = '0;
    logic signed [15:0] dbm2 = '0;
    logic range_up = 1'b0;
    logic range_dn = 1'b0;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic wr = 1'b0;
    logic rd = 1'b0;
    kpl_view_type view;
    logic [15:0] digits;
    logic [2:0] frac;
    logic point, neg, rel, lamp, conn;
    logic [1:0] chan, range;
    logic [21:0] zo;
    int failures = 0;
    int samples_checked = 0;

    kpl_panel i_kpl_panel (.sys_clk_i, .rst_b_i, .key_i(key),
        .level_mv_ch1_i(mv1), .level_mv_ch2_i(16'h0),
        .level_dbmv_ch1_i(dbmv1), .level_dbmv_ch2_i(16'sh0),
        .level_dbm_ch1_i(dbm1), .level_dbm_ch2_i(dbm2),
        .range_up_i(range_up), .range_down_i(range_dn),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
        .reg_read_i(rd), .reg_rdata_o(rdata), .view_o(view),
        .entry_digits_o(digits), .entry_frac_o(frac),
        .entry_point_o(point), .entry_neg_o(neg), .channel_o(chan),
        .impedance_o(zo), .range_o(range),
        .threshold_alarm_lamp_o(lamp), .alarm_output_connector_o(conn),
        .relative_level_lamp_o(rel));
    kpl_keypad_model i_kpl_keypad_model (.sys_clk_i, .key_o(key));

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // ----
    // Helpers
    // ----
    task automatic settle;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    // A human keys at uneven speed, so gaps are random
    task automatic k(input logic [4:0] c);
        i_kpl_keypad_model.press(c, $urandom_range(2));
    endtask
    task automatic enter(input int v, input bit n, input logic [4:0] fn);
        string s;
        s = $sformatf("%0d", v);
        for (int i = 0; i < s.len(); i++) begin
            k(5'(s[i] - "0"));
        end
        if (n) k(KEY_SIGN_TOGGLE);
        k(fn);
        settle();
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    function automatic logic alarm_of(input int d);
        return (d > 1000) || (d < -1000);
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        end_of_test();
    end

    // ----
    // Scenarios
    // ----
    initial begin
        int lvl;
        int cases[4] = '{1500, -500, 1501, -501};
        void'($urandom(32'he46c0fe8));
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd_chk(OFS_CTRL, CTRL_RESET);
        rd_chk(4'hc, 32'h0);
        wr_reg(OFS_CTRL, 32'h0);
        rd_chk(OFS_CTRL, 32'h0);
        wr_reg(OFS_CTRL, 32'h1);
        k(KEY_RANGE_HOLD);
        range_up <= 1'b1;
        settle();
        settle();
        `CHK(range, 2'h0)
        k(KEY_RANGE_AUTO);
        settle();
        settle();
        `CHK(range, RANGE_TOP)
        range_up <= 1'b0;
        range_dn <= 1'b1;
        settle();
        settle();
        rd_chk(OFS_RANGE, 32'h0);
        range_dn <= 1'b0;
        // Fifth digit and second point must both be dropped
        k(5'h3); k(5'h1); k(KEY_POINT); k(5'h3); k(5'h4);
        k(5'h5); k(KEY_POINT); k(KEY_SIGN_TOGGLE);
        settle();
        `CHK(view.kind, VIEW_ENTRY)
        `CHK({digits, frac, point, neg}, {16'h3134, 5'h0b})
        enter(0, 0, KEY_LOW_THRESHOLD);
        k(KEY_LOW_THRESHOLD);
        settle();
        `CHK({view.kind, view.value}, {VIEW_RECALL, -22'sd3134})
        k(5'h7);
        k(KEY_ERASE_ENTRY);
        settle();
        `CHK({digits, neg}, 17'h0)
        enter(10, 1, KEY_LOW_THRESHOLD);
        enter(10, 0, KEY_HIGH_THRESHOLD);
        enter(4, 0, KEY_IMPEDANCE_CHOICE);
        `CHK({view.kind, view.value}, {VIEW_ERROR, 22'(ERR_SMALL)})
        k(KEY_ERASE_ENTRY);
        enter(601, 0, KEY_IMPEDANCE_CHOICE);
        `CHK({view.kind, view.value}, {VIEW_ERROR, 22'(ERR_LARGE)})
        k(KEY_ERASE_ENTRY);
        enter(100, 0, KEY_HIGH_THRESHOLD);
        `CHK(view.value, 22'(ERR_LARGE))
        k(KEY_ERASE_ENTRY);
        enter(600, 0, KEY_IMPEDANCE_CHOICE);
        `CHK(zo, ZO_MAX)
        k(KEY_LOG_POWER);
        enter(5, 0, KEY_REFERENCE_OFFSET);
        `CHK(rel, 1'b1)
        k(KEY_REFERENCE_OFFSET);
        settle();
        `CHK({view.kind, view.value}, {VIEW_RECALL, 22'sd500})
        k(KEY_LOG_POWER);
        for (int i = 0; i < 24; i++) begin
            lvl = (i < 4) ? cases[i] : $urandom_range(3000) - 1500;
            @(posedge sys_clk_i);
            dbm1 <= 16'(lvl);
            dbmv1 <= 16'($urandom);
            mv1 <= 16'($urandom);
            settle();
            `CHK({view.kind, view.value}, {VIEW_DB, 22'(lvl - 500)})
            `CHK({lamp, conn}, {2{alarm_of(lvl - 500)}})
        end
        k(KEY_LOG_VOLT);
        settle();
        `CHK(view.value, 22'(dbmv1) - DBV_SHIFT)
        k(KEY_LOG_MILLIVOLT);
        settle();
        `CHK({view.kind, view.value}, {VIEW_DB, 22'(dbmv1)})
        k(KEY_LOG_POWER);
        k(KEY_LINEAR_VOLTS);
        settle();
        `CHK({view.kind, lamp}, {VIEW_MV, alarm_of(lvl - 500)})
        `CHK(view.value, 22'(mv1))
        enter(2, 0, KEY_CHANNEL_CHOICE);
        `CHK({chan, rel, lamp, zo}, {4'h8, ZO_MIN})
        enter(3, 0, KEY_CHANNEL_CHOICE);
        `CHK({view.kind, view.value}, {VIEW_DIFF, 22'(lvl - 500)})
        `CHK(lamp, alarm_of(lvl - 500))
        // Channel 2 alone over its high limit must still light the lamp
        @(posedge sys_clk_i);
        dbm2 <= 16'sd10000;
        settle();
        `CHK({view.value, lamp}, {22'(lvl - 10500), 1'b1})
        @(posedge sys_clk_i);
        rst_b_i <= 1'b0;
        @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        settle();
        `CHK(chan, 2'h3)
        rd_chk(OFS_STATUS, 32'h0000_011c);
        end_of_test();
    end
endmodule
